// >>> rtl/tdc_control_status_registers.sv
// configuration and status register bank reached through the test-port scan chains
// assumes the test-port state machine lives outside and drives decoded states on pins;
// core status and event strobes arrive on clk_in
//
// Summary of operation
// [R01] error output is high when any enabled error flag is set
// [R02] event count reset inserts a separator when its option is set
// [R03] bunch count reset inserts a separator when its option is set
// [R04] separators reach read-out only with the debug read-out option
// [R05] reject event data on trigger FIFO nearly full when enabled
// [R06] reject event data on hit buffer nearly full when enabled
// [R07] reject event data on read-out FIFO full when enabled
// [R08] 24 channel enable bits over two registers gate hit inputs
// [R09] 12-bit general output drives data pins 23..12 in front-end mode
// [R10] general output loads through its own scan path
// [R11] status registers are read only; scan writes leave them unchanged
// [R12] nine error flags in the documented bit order
// [R13] after reset empties, control parity and overflow-recover read one
// [R14] instruction parity error sets error flag bit 8
// [R15] instruction is stored and executed despite a parity error
// [R16] report hit buffer write pointer with its four flags
// [R17] report run level, hit buffer read pointer and trigger FIFO flags
// [R18] report trigger FIFO occupancy and hit buffer start pointer
// [R19] coarse counter bit 0 beside occupancy, bits 12..1 next
// [R20] report six-bit read-out FIFO occupancy
// [R21] data pins 27..24 read as general inputs in front-end mode
// [R22] registers are read and written through the test port
// [R23] instruction register is four bits plus one parity bit
// [R24] instruction 1010 selects the status chain
// [R25] all status fields captured in one clock cycle
`timescale 1ns/10ps

module tdc_control_status_registers
  import tdc_csr_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  // test port
  input  wire tdc_csr_pkg::tap_pins_t    tap_in,
  output logic                           tdo_out,
  // core status and strobes
  input  wire tdc_csr_pkg::core_status_t core_status_in,
  input  wire logic                      event_count_reset_in,
  input  wire logic                      bunch_count_reset_in,
  input  wire tdc_csr_pkg::reject_en_t   reject_en_in,
  // pins
  input  wire logic                      run_start_pin_in,
  input  wire logic                      frontend_ctrl_mode_pin_in,
  input  wire logic [3:0]                dio_high_pins_in,
  output logic [11:0]                    dio_mid_pins_out,
  output logic [11:0]                    dio_mid_pins_oe_b_out,
  output logic                           frontend_serial_in_out,
  // to the core
  output logic                           error_output_pin_out,
  output logic                           separator_insert_out,
  output logic                           separator_readout_en_out,
  output logic                           event_reject_out,
  output logic [23:0]                    channel_enable_out
);

  import tdc_csr_pkg::*;

  typedef struct packed {
    tap_pins_t     tap_s1;
    tap_pins_t     tap_s2;
    logic          tck_d;
    logic          run_s1;
    logic          run_s2;
    logic          mode_s1;
    logic          mode_s2;
    logic [3:0]    gin_s1;
    logic [3:0]    gin_s2;
    logic [4:0]    ir_shift;
    logic [3:0]    ir;
    logic          ins_parity_err;
    logic [35:0]   ctrl_shift;
    logic [35:0]   ctrl;
    logic [11:0]   gpo_shift;
    logic [11:0]   gpo;
    logic [71:0]   stat_shift;
    logic          bypass;
    logic          tdo;
    logic          error;
    logic          sep_insert;
    logic          reject;
    logic [11:0]   dio_out;
    logic [11:0]   dio_oe_b;
    logic          serial_in;
  } state_t;

  localparam state_t STATE_RESET = '{
    tap_s1:         '0,
    tap_s2:         '0,
    tck_d:          1'b0,
    run_s1:         1'b0,
    run_s2:         1'b0,
    mode_s1:        1'b0,
    mode_s2:        1'b0,
    gin_s1:         4'h0,
    gin_s2:         4'h0,
    ir_shift:       5'h00,
    ir:             IR_RESET,
    ins_parity_err: 1'b0,
    ctrl_shift:     CTRL_RESET,
    ctrl:           CTRL_RESET,
    gpo_shift:      GPO_RESET,
    gpo:            GPO_RESET,
    stat_shift:     STAT_RESET,
    bypass:         1'b0,
    tdo:            1'b0,
    error:          1'b0,
    sep_insert:     1'b0,
    reject:         1'b0,
    dio_out:        12'h000,
    dio_oe_b:       12'hFFF,
    serial_in:      1'b0
  };

  state_t state_reg;
  state_t state_next;

  // gathers a coherent status word from the core, the pins and the parity flag;
  // each 12-bit slice is one read-only status register, lowest register first
  function automatic logic [71:0] status_word(input core_status_t cs,
                                              input logic        par_err,
                                              input logic        running,
                                              input logic [3:0]  gen_in);
    logic [11:0] err_slice;
    logic [11:0] wr_slice;
    logic [11:0] rd_slice;
    logic [11:0] start_slice;
    logic [11:0] count_slice;
    logic [11:0] occ_slice;
    // [R12] error flags, then control parity and read-out FIFO flags
    err_slice   = {cs.rfifo_empty, cs.rfifo_full, cs.control_parity,
                   par_err, cs.error_flags};
    // [R16] hit buffer write pointer with its four flags
    wr_slice    = {cs.hit_buffer_empty, cs.hit_buffer_almost_full,
                   cs.hit_buffer_overflow_recover, cs.hit_buffer_overflow,
                   cs.hit_buffer_wr_ptr};
    // [R17] trigger FIFO flags, run level and hit buffer read pointer
    rd_slice    = {cs.tfifo_empty, cs.tfifo_nearly_full, cs.tfifo_full, running,
                   cs.hit_buffer_rd_ptr};
    // [R18] [R19] coarse bit 0, trigger FIFO occupancy and start pointer
    start_slice = {cs.coarse_counter[0], cs.tfifo_occupancy, cs.hit_buffer_start_ptr};
    // [R19] upper coarse counter bits
    count_slice = cs.coarse_counter[12:1];
    // [R20] [R21] general inputs, two zero bits, read-out FIFO occupancy
    occ_slice   = {gen_in, 2'b00, cs.rfifo_occupancy};
    status_word = {occ_slice, count_slice, start_slice, rd_slice, wr_slice, err_slice};
  endfunction

  // [R14] parity bit must equal the xor of the four code bits
  function automatic logic ir_parity_bad(input logic [4:0] ir_word);
    ir_parity_bad = (^ir_word[IR_WIDTH-1:0]) != ir_word[IR_WIDTH];
  endfunction

  // head of the data chain that the current instruction selects;
  // unknown codes fall back to the one-bit bypass stage
  function automatic logic chain_head(input logic [3:0] ins,
                                      input logic       ctrl_bit,
                                      input logic       gpo_bit,
                                      input logic       stat_bit,
                                      input logic       bypass_bit);
    unique case (ins)
      INS_CONTROL:     chain_head = ctrl_bit;
      INS_GENERAL_OUT: chain_head = gpo_bit;
      INS_STATUS:      chain_head = stat_bit;
      default:         chain_head = bypass_bit;
    endcase
  endfunction

  // [R01] error pin: any flag whose enable bit is set
  function automatic logic error_active(input logic [8:0] flags,
                                        input logic [8:0] enables);
    error_active = |(flags & enables);
  endfunction

  // [R02] [R03] a count reset strobe inserts a separator when its option is set
  function automatic logic separator_cause(input logic        evrst,
                                           input logic        bcrst,
                                           input logic [35:0] ctrl_word);
    separator_cause = (evrst & ctrl_word[SEPA_EVRST_BIT]) |
                      (bcrst & ctrl_word[SEPA_BCRST_BIT]);
  endfunction

  // [R05] [R06] [R07] any enabled full condition rejects event data
  function automatic logic reject_cause(input reject_en_t   en,
                                        input core_status_t cs);
    reject_cause = (en.trigger_fifo_reject_en & cs.tfifo_nearly_full) |
                   (en.hit_buffer_reject_en & cs.hit_buffer_almost_full) |
                   (en.readout_fifo_reject_en & cs.rfifo_full);
  endfunction

  logic       tck_rise;
  logic [8:0] all_errors;
  logic [3:0] gen_in;

  always_comb
  begin
    state_next = state_reg;
    tck_rise   = state_reg.tap_s2.tck & ~state_reg.tck_d;
    gen_in     = state_reg.mode_s2 ? state_reg.gin_s2 : 4'h0;

    // pin synchronisers; tck is sampled as data, not used as a clock,
    // so each tck level must last several clk cycles
    state_next.tap_s1  = tap_in;
    state_next.tap_s2  = state_reg.tap_s1;
    state_next.tck_d   = state_reg.tap_s2.tck;
    state_next.run_s1  = run_start_pin_in;
    state_next.run_s2  = state_reg.run_s1;
    state_next.mode_s1 = frontend_ctrl_mode_pin_in;
    state_next.mode_s2 = state_reg.mode_s1;
    state_next.gin_s1  = dio_high_pins_in;
    state_next.gin_s2  = state_reg.gin_s1;

    if (tck_rise)
    begin
      // [R23] five-bit instruction shift
      if (state_reg.tap_s2.shift_ir)
      begin
        state_next.ir_shift = {state_reg.tap_s2.tdi, state_reg.ir_shift[4:1]};
      end
      if (state_reg.tap_s2.update_ir)
      begin
        // [R15] stored regardless of parity
        state_next.ir = state_reg.ir_shift[IR_WIDTH-1:0];
        // [R14] even parity check sets flag; it stays set until reset
        if (ir_parity_bad(state_reg.ir_shift))
        begin
          state_next.ins_parity_err = 1'b1;
        end
      end

      // [R22] data chains selected by instruction
      unique case (state_reg.ir)
        INS_CONTROL:
        begin
          if (state_reg.tap_s2.capture_dr)
          begin
            state_next.ctrl_shift = state_reg.ctrl;
          end
          else if (state_reg.tap_s2.shift_dr)
          begin
            state_next.ctrl_shift = {state_reg.tap_s2.tdi, state_reg.ctrl_shift[35:1]};
          end
          else if (state_reg.tap_s2.update_dr)
          begin
            state_next.ctrl = state_reg.ctrl_shift;
          end
        end
        // [R10] separate general output path
        INS_GENERAL_OUT:
        begin
          if (state_reg.tap_s2.capture_dr)
          begin
            state_next.gpo_shift = state_reg.gpo;
          end
          else if (state_reg.tap_s2.shift_dr)
          begin
            state_next.gpo_shift = {state_reg.tap_s2.tdi, state_reg.gpo_shift[11:1]};
          end
          else if (state_reg.tap_s2.update_dr)
          begin
            state_next.gpo = state_reg.gpo_shift;
          end
        end
        // [R24] status chain
        INS_STATUS:
        begin
          // [R25] single-cycle snapshot
          if (state_reg.tap_s2.capture_dr)
          begin
            state_next.stat_shift = status_word(core_status_in, state_reg.ins_parity_err,
                                                state_reg.run_s2, gen_in);
          end
          // [R11] shifted bits only move through stat_shift, never into ctrl or gpo
          else if (state_reg.tap_s2.shift_dr)
          begin
            state_next.stat_shift = {state_reg.tap_s2.tdi, state_reg.stat_shift[71:1]};
          end
          // [R11] update commits nothing for the status chain
          else if (state_reg.tap_s2.update_dr)
          begin
            state_next.stat_shift = state_reg.stat_shift;
          end
        end
        default:
        begin
          if (state_reg.tap_s2.capture_dr)
          begin
            state_next.bypass = 1'b0;
          end
          else if (state_reg.tap_s2.shift_dr)
          begin
            state_next.bypass = state_reg.tap_s2.tdi;
          end
        end
      endcase
    end

    // serial output follows the head of the selected chain
    if (state_reg.tap_s2.shift_ir)
    begin
      state_next.tdo = state_reg.ir_shift[0];
    end
    else
    begin
      state_next.tdo = chain_head(state_reg.ir, state_reg.ctrl_shift[0],
                                  state_reg.gpo_shift[0], state_reg.stat_shift[0],
                                  state_reg.bypass);
    end

    // [R12] flag 8 is the instruction parity error
    all_errors = {state_reg.ins_parity_err, core_status_in.error_flags};
    // [R01] enabled flags drive error pin
    state_next.error = error_active(all_errors, state_reg.ctrl[ERR_EN_LSB +: 9]);

    // [R02] [R03] separator on resets, one cycle per strobe
    state_next.sep_insert = separator_cause(event_count_reset_in, bunch_count_reset_in,
                                            state_reg.ctrl);

    // [R05] [R06] [R07] rejection conditions follow the core flags one cycle late
    state_next.reject = reject_cause(reject_en_in, core_status_in);

    // [R09] general output onto pins in front-end mode
    state_next.dio_out  = state_reg.gpo;
    state_next.dio_oe_b = state_reg.mode_s2 ? 12'h000 : 12'hFFF;
    // [R21] general input bit 3 is the front-end serial input
    state_next.serial_in = gen_in[3];
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    // [R13] status chain reset pattern
    if (!rst_b_in)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign tdo_out                  = state_reg.tdo;
  assign error_output_pin_out     = state_reg.error;
  assign separator_insert_out     = state_reg.sep_insert;
  // [R04] separator read-out option
  assign separator_readout_en_out = state_reg.ctrl[SEPA_RDOUT_BIT];
  assign event_reject_out         = state_reg.reject;
  // [R08] two 12-bit halves form channel enables
  assign channel_enable_out       = {state_reg.ctrl[CHAN_HIGH_LSB +: 12],
                                     state_reg.ctrl[CHAN_LOW_LSB +: 12]};
  assign dio_mid_pins_out         = state_reg.dio_out;
  assign dio_mid_pins_oe_b_out    = state_reg.dio_oe_b;
  assign frontend_serial_in_out   = state_reg.serial_in;

endmodule

// >>> rtl/tdc_csr_pkg.sv
// constants and carrier types for the converter's configuration and status bank
// assumes a test-port controller outside that decodes its state machine onto pins
package tdc_csr_pkg;

  // test-port instruction codes, 4 bits plus one even-parity bit
  localparam int          IR_WIDTH       = 4;
  localparam logic [3:0]  INS_CONTROL    = 4'h8;
  localparam logic [3:0]  INS_STATUS     = 4'hA;
  localparam logic [3:0]  INS_GENERAL_OUT = 4'hD;
  localparam logic [3:0]  INS_BYPASS     = 4'hF;
  localparam logic [3:0]  IR_RESET       = INS_BYPASS;

  // chain lengths
  localparam int          CTRL_LEN       = 36;
  localparam int          GPO_LEN        = 12;
  localparam int          STAT_LEN       = 72;

  // field positions inside the control chain (error_enable_separator_ctrl first)
  localparam int          ERR_EN_LSB     = 0;
  localparam int          SEPA_EVRST_BIT = 9;
  localparam int          SEPA_BCRST_BIT = 10;
  localparam int          SEPA_RDOUT_BIT = 11;
  localparam int          CHAN_LOW_LSB   = 12;
  localparam int          CHAN_HIGH_LSB  = 24;

  // values after reset
  localparam logic [35:0] CTRL_RESET     = 36'h0_0000_0000;
  localparam logic [11:0] GPO_RESET      = 12'h000;
  // empty flags, control parity and overflow-recover read one, all else zero
  localparam logic [71:0] STAT_RESET     = 72'h00_0000_0008_00A0_0A00;

  // status fields delivered by the converter core on the device clock
  typedef struct packed {
    logic [7:0]  error_flags;
    logic        control_parity;
    logic        rfifo_full;
    logic        rfifo_empty;
    logic [5:0]  rfifo_occupancy;
    logic [7:0]  hit_buffer_wr_ptr;
    logic        hit_buffer_overflow;
    logic        hit_buffer_overflow_recover;
    logic        hit_buffer_almost_full;
    logic        hit_buffer_empty;
    logic [7:0]  hit_buffer_rd_ptr;
    logic [7:0]  hit_buffer_start_ptr;
    logic        tfifo_full;
    logic        tfifo_nearly_full;
    logic        tfifo_empty;
    logic [2:0]  tfifo_occupancy;
    logic [12:0] coarse_counter;
  } core_status_t;

  // decoded test-port signals arriving from pins
  typedef struct packed {
    logic tck;
    logic tdi;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic shift_ir;
    logic update_ir;
  } tap_pins_t;

  // reject enables held in an earlier control register
  typedef struct packed {
    logic trigger_fifo_reject_en;
    logic hit_buffer_reject_en;
    logic readout_fifo_reject_en;
  } reject_en_t;

endpackage

// >>> testbench/tap_ctrl_model.sv
// test-port controller model stepping decoded states onto the scan pins
// assumes the bank synchronises the pins to clk_in
`timescale 1ns/10ps
module tap_ctrl_model (
  input  wire logic              clk_in,
  input  wire logic              tdo_in,
  output tdc_csr_pkg::tap_pins_t tap_out
);
  import tdc_csr_pkg::*;
  initial tap_out = '0;
  // one state per tck pulse, tck at least 7 clk low and 8 clk high
  task automatic tick(input logic [4:0] st, input logic d);
    @(negedge clk_in);
    tap_out = {1'b0, d, st};
    repeat (6) @(negedge clk_in);
    tap_out.tck = 1'b1;
    repeat (8) @(negedge clk_in);
    tap_out.tck = 1'b0;
  endtask
  // four code bits first, then even parity, flipped on request
  task automatic load_ir(input logic [3:0] code, input logic bad);
    logic [4:0] v;
    v = {^code ^ bad, code};
    for (int i = 0; i < 5; i++)
      tick(5'b00010, v[i]);
    tick(5'b00001, ~v[4]);
  endtask
  // capture, shift n bits collecting the chain head, update
  task automatic scan(input int n, input logic [71:0] din, output logic [71:0] dout);
    dout = '0;
    tick(5'b10000, ~din[0]);
    for (int i = 0; i < n; i++)
    begin
      dout[i] = tdo_in;
      tick(5'b01000, din[i]);
    end
    tick(5'b00100, ~din[n-1]);
  endtask
endmodule

// >>> testbench/tdc_control_status_registers_tb.sv
// self-checking bench for the configuration and status bank
// assumes the controller model drives the scan pins
`timescale 1ns/10ps
module tdc_control_status_registers_tb;
  import tdc_csr_pkg::*;
  logic         clk_in, rst_b_in, tdo, evr, bcr, run, mode, fsi, errp, sep, sepro, rejo;
  tap_pins_t    tap;
  core_status_t cs;
  reject_en_t   rej;
  logic [3:0]   dhi;
  logic [11:0]  dmid, oeb;
  logic [23:0]  chan;
  logic [71:0]  got, ctrl, c0, g;
  int           seed = 98515;
  int           n_mismatch = 0;
  int           total_checks = 0;

  tdc_control_status_registers i_dut (.clk_in, .rst_b_in, .tap_in(tap), .tdo_out(tdo),
    .core_status_in(cs), .event_count_reset_in(evr), .bunch_count_reset_in(bcr),
    .reject_en_in(rej), .run_start_pin_in(run), .frontend_ctrl_mode_pin_in(mode),
    .dio_high_pins_in(dhi), .dio_mid_pins_out(dmid), .dio_mid_pins_oe_b_out(oeb),
    .frontend_serial_in_out(fsi), .error_output_pin_out(errp), .separator_insert_out(sep),
    .separator_readout_en_out(sepro), .event_reject_out(rejo), .channel_enable_out(chan));
  tap_ctrl_model i_tap (.clk_in, .tdo_in(tdo), .tap_out(tap));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  function automatic logic [71:0] stat_exp(input logic pe);
    return {mode ? dhi : 4'h0, 2'b00, cs.rfifo_occupancy, cs.coarse_counter,
      cs.tfifo_occupancy, cs.hit_buffer_start_ptr, cs.tfifo_empty, cs.tfifo_nearly_full,
      cs.tfifo_full, run, cs.hit_buffer_rd_ptr, cs.hit_buffer_empty,
      cs.hit_buffer_almost_full, cs.hit_buffer_overflow_recover, cs.hit_buffer_overflow,
      cs.hit_buffer_wr_ptr, cs.rfifo_empty, cs.rfifo_full, cs.control_parity, pe,
      cs.error_flags};
  endfunction

  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic write_ctrl(input logic [71:0] c, input logic bad);
    ctrl = c;
    i_tap.load_ir(INS_CONTROL, bad);
    i_tap.scan(CTRL_LEN, ctrl, got);
    repeat (4) @(negedge clk_in);
    check("channel_enable", chan, ctrl[35:12]);
    check("separator_readout", sepro, ctrl[11]);
  endtask

  initial
  begin
    {evr, bcr, run, mode, dhi, rej} = '0;
    cs = '0;
    rst_b_in = 1'b0;
    repeat (5) @(negedge clk_in);
    check("oe_b_reset", oeb, 12'hFFF);
    check("channel_reset", chan, 24'h0);
    rst_b_in = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      cs = {$random(seed), $random(seed)};
      {mode, run} = k[1:0];
      dhi = 4'($random(seed));
      i_tap.load_ir(INS_STATUS, 1'b0);
      i_tap.scan(STAT_LEN, {$random(seed), $random(seed)}, got);
      check("status", got, stat_exp(1'b0));
      check("serial_in", fsi, mode & dhi[3]);
    end
    c0 = {$random(seed), $random(seed)};
    for (int j = 0; j < 2; j++)
    begin
      write_ctrl(j ? ~c0 : c0, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
        cs.error_flags = 8'h01 << i;
        @(negedge clk_in);
        check("error_out", errp, ctrl[i]);
      end
      evr = 1'b1;
      @(negedge clk_in);
      evr = 1'b0;
      bcr = 1'b1;
      check("sep_event", sep, ctrl[9]);
      @(negedge clk_in);
      bcr = 1'b0;
      check("sep_bunch", sep, ctrl[10]);
      i_tap.load_ir(INS_STATUS, 1'b0);
      i_tap.scan(STAT_LEN, {$random(seed), $random(seed)}, got);
      check("channel_kept", chan, ctrl[35:12]);
    end
    for (int k = 0; k < 24; k++)
    begin
      rej = 3'($random(seed));
      cs = {$random(seed), $random(seed)};
      @(negedge clk_in);
      check("reject", rejo, (rej.trigger_fifo_reject_en & cs.tfifo_nearly_full)
        | (rej.hit_buffer_reject_en & cs.hit_buffer_almost_full)
        | (rej.readout_fifo_reject_en & cs.rfifo_full));
    end
    mode = 1'b1;
    g = {$random(seed)};
    i_tap.load_ir(INS_GENERAL_OUT, 1'b0);
    i_tap.scan(GPO_LEN, g, got);
    repeat (4) @(negedge clk_in);
    check("gpo_pins", dmid, g[11:0]);
    check("gpo_enable", oeb, 12'h000);
    check("gpo_apart", chan, ctrl[35:12]);
    write_ctrl(c0 | 72'h100, 1'b1);
    cs.error_flags = 8'h00;
    @(negedge clk_in);
    check("parity_error_out", errp, 1'b1);
    i_tap.load_ir(INS_STATUS, 1'b0);
    i_tap.scan(STAT_LEN, '0, got);
    check("parity_flag", got[8], 1'b1);
    report_and_stop;
  end

  initial
  begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
endmodule

bind tdc_control_status_registers tdc_csr_props i_props (.clk_in, .rst_b_in, .tap_in,
  .core_status_in, .event_count_reset_in, .bunch_count_reset_in, .reject_en_in,
  .frontend_ctrl_mode_pin_in, .dio_high_pins_in, .dio_mid_pins_oe_b_out,
  .frontend_serial_in_out, .separator_insert_out, .separator_readout_en_out,
  .event_reject_out, .channel_enable_out);

// >>> testbench/tdc_csr_props.sv
// port assertions for the configuration and status bank
// assumes a bind onto the bank top and a single clock domain
`timescale 1ns/10ps
module tdc_csr_props (
  input wire logic                      clk_in,
  input wire logic                      rst_b_in,
  input wire tdc_csr_pkg::tap_pins_t    tap_in,
  input wire tdc_csr_pkg::core_status_t core_status_in,
  input wire logic                      event_count_reset_in,
  input wire logic                      bunch_count_reset_in,
  input wire tdc_csr_pkg::reject_en_t   reject_en_in,
  input wire logic                      frontend_ctrl_mode_pin_in,
  input wire logic [3:0]                dio_high_pins_in,
  input wire logic [11:0]               dio_mid_pins_oe_b_out,
  input wire logic                      frontend_serial_in_out,
  input wire logic                      separator_insert_out,
  input wire logic                      separator_readout_en_out,
  input wire logic                      event_reject_out,
  input wire logic [23:0]               channel_enable_out
);
  import tdc_csr_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic rej_cause;
  assign rej_cause = (reject_en_in.trigger_fifo_reject_en & core_status_in.tfifo_nearly_full)
    | (reject_en_in.hit_buffer_reject_en & core_status_in.hit_buffer_almost_full)
    | (reject_en_in.readout_fifo_reject_en & core_status_in.rfifo_full);
  sequence mode_s(m);
    (frontend_ctrl_mode_pin_in == m) [*5];
  endsequence
  sequence quiet_s;
    !tap_in.update_dr [*8];
  endsequence
  sep_cause_a:
    assert property (separator_insert_out |-> $past(event_count_reset_in | bunch_count_reset_in))
    else $error("separator without a reset strobe");
  sep_pulse_a:
    assert property (separator_insert_out && !event_count_reset_in && !bunch_count_reset_in
      |=> !separator_insert_out) else $error("separator longer than one cycle");
  reject_on_a:
    assert property (rej_cause |=> event_reject_out) else $error("reject missing");
  reject_off_a:
    assert property (!rej_cause |=> !event_reject_out) else $error("reject without cause");
  pins_drive_a:
    assert property (mode_s(1) |=> dio_mid_pins_oe_b_out == 12'h000)
    else $error("general outputs not driven");
  pins_release_a:
    assert property (mode_s(0) |=> dio_mid_pins_oe_b_out == 12'hFFF)
    else $error("general outputs not released");
  serial_low_a:
    assert property (mode_s(0) |=> !frontend_serial_in_out) else $error("serial input not zero");
  serial_in_a:
    assert property ((frontend_ctrl_mode_pin_in && $stable(dio_high_pins_in[3])) [*5]
      |=> frontend_serial_in_out == $past(dio_high_pins_in[3])) else $error("serial input wrong");
  ctrl_hold_a:
    assert property (quiet_s |=> $stable(channel_enable_out) && $stable(separator_readout_en_out))
    else $error("control changed without update");
endmodule
